//--- ddc_pkg.sv
package ddc_pkg;
  // ----------------------------------------------------------------
  // Geometry, address layout and timing
  // ----------------------------------------------------------------
  localparam int NUM_CS = 2;
  localparam int NUM_BANKS = 4;
  localparam int NUM_ENTRIES = NUM_CS * NUM_BANKS;
  localparam int ROW_W = 12;
  localparam int MADDR_W = 14;
  localparam int CS_BIT = 28;
  localparam int COL_HI_MSB = 27;
  localparam int COL_HI_LSB = 24;
  localparam int ROW_MSB = 23;
  localparam int ROW_LSB = 12;
  localparam int BANK_MSB = 11;
  localparam int BANK_LSB = 10;
  localparam int COL_LO_MSB = 9;
  localparam int COL_LO_LSB = 1;
  localparam int BURST_HALVES = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CMD_GAP_NS = 20;
  localparam int REF_INTERVAL_NS = 7800;
  // Least gap rounds up; refresh interval is a longest time and rounds down.
  localparam int CMD_GAP_CYC = (CMD_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REF_INTERVAL_CYC = REF_INTERVAL_NS / CLK_PERIOD_NS;
  localparam logic [3:0] GAP_LOAD = 4'(CMD_GAP_CYC);
  localparam logic [9:0] REF_LOAD = 10'(REF_INTERVAL_CYC);
  localparam logic [3:0] HALF_LAST = 4'(BURST_HALVES - 1);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_PRECHARGE_ALL_COMMAND = 7'h02,
    ST_REF = 7'h04,
    ST_LMR = 7'h08,
    ST_PRE = 7'h10,
    ST_ACT = 7'h20,
    ST_XFER = 7'h40
  } ddc_state_t;

  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_PRECHARGE_ALL_COMMAND = 3'h1,
    CMD_PRE = 3'h2,
    CMD_ACT = 3'h3,
    CMD_RD = 3'h4,
    CMD_WR = 3'h5,
    CMD_REF = 3'h6,
    CMD_LMR = 3'h7
  } ddc_cmd_t;

  typedef struct packed {
    logic auto_refresh_enable;
    logic init_refresh;
    logic init_precharge_all;
    logic mode_write_enable;
  } ddc_ctl_t;

  typedef struct packed {
    logic write;
    logic [31:0] addr;
  } ddc_req_t;

  typedef struct packed {
    ddc_cmd_t cmd;
    logic [NUM_CS-1:0] cs_n;
    logic [1:0] bank;
    logic [MADDR_W-1:0] addr;
    logic [15:0] wdata;
    logic wvalid;
  } ddc_mem_t;
endpackage : ddc_pkg

//--- ddc_fifo.sv
module ddc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] count;
  } ddc_fifo_st_t;

  ddc_fifo_st_t st_reg;
  ddc_fifo_st_t st_next;
  logic [WIDTH-1:0] store [DEPTH];
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready = (st_reg.count != (AW+1)'(DEPTH));
  assign out_valid = (st_reg.count != '0);
  assign out_data = store[st_reg.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and count update.
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wp = st_reg.wp + AW'(1);
    end
    if (pop) begin
      st_next.rp = st_reg.rp + AW'(1);
    end
    st_next.count = st_reg.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Storage has no reset; only written slots are ever read.
  always_ff @(posedge ref_clk) begin
    if (push) begin
      store[st_reg.wp] <= in_data;
    end
  end
endmodule : ddc_fifo

//--- ddc_ctrl.sv
module ddc_ctrl (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ctrl_wr,
  input wire ddc_pkg::ddc_ctl_t ctrl_in,
  input wire logic mode_wr,
  input wire logic [1:0] mode_sel,
  input wire logic [ddc_pkg::MADDR_W-1:0] memory_mode_value,
  output logic mode_locked,
  output logic ctrl_busy,
  input wire logic req_valid,
  output logic req_ready,
  input wire ddc_pkg::ddc_req_t req,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [31:0] wr_data,
  output logic rd_valid,
  output logic [31:0] rd_data,
  output ddc_pkg::ddc_mem_t mem_out,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_rvalid
);
  localparam int GAP_CYC = ddc_pkg::CMD_GAP_CYC;
  localparam int GAP_WIN = GAP_CYC + 2; // Gap countdown plus the issuing cycle.
  typedef struct packed {
    ddc_pkg::ddc_state_t st;
    ddc_pkg::ddc_ctl_t ctl;
    logic precharge_all_command_pend;
    logic init_refresh_pend;
    logic lmr_pend;
    logic [1:0] lmr_sel;
    logic [ddc_pkg::MADDR_W-1:0] lmr_val;
    logic then_ref;
    logic [ddc_pkg::NUM_ENTRIES-1:0] open_vld;
    logic [ddc_pkg::NUM_ENTRIES-1:0][ddc_pkg::ROW_W-1:0] open_row;
    ddc_pkg::ddc_req_t cur;
    logic [3:0] wait_cnt;
    logic [3:0] half_cnt;
    logic [9:0] ref_cnt;
    logic ref_due;
    logic [15:0] lo_half;
    logic rd_valid;
    logic [31:0] rd_data;
    ddc_pkg::ddc_mem_t mem;
    logic [16:0] sync1;
    logic [16:0] sync2;
  } ddc_st_t;
  ddc_st_t s_reg;
  ddc_st_t s_next;
  logic fifo_valid;
  logic fifo_pop;
  logic [31:0] fifo_data;
  logic idle_free;
  logic req_hit;
  logic [2:0] req_idx;
  logic [2:0] cur_idx;
  logic [ddc_pkg::ROW_W-1:0] req_row;
  logic [ddc_pkg::ROW_W-1:0] cur_row;
  logic [ddc_pkg::MADDR_W-1:0] cur_col;
  logic rvalid_s;
  logic [15:0] rdata_s;
  // ----------------------------------------------------------------
  // Write data buffer
  // ----------------------------------------------------------------
  // The write burst drains this buffer; an empty buffer stalls the burst.
  ddc_fifo #(.WIDTH(32), .DEPTH(ddc_pkg::FIFO_DEPTH)) ddc_fifo_i (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );
  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Tracking entry index is chip-select then bank, one row per entry.
  assign req_idx = {req.addr[ddc_pkg::CS_BIT], req.addr[ddc_pkg::BANK_MSB:ddc_pkg::BANK_LSB]};
  assign req_row = req.addr[ddc_pkg::ROW_MSB:ddc_pkg::ROW_LSB];
  assign cur_idx = {s_reg.cur.addr[ddc_pkg::CS_BIT], s_reg.cur.addr[ddc_pkg::BANK_MSB:ddc_pkg::BANK_LSB]};
  assign cur_row = s_reg.cur.addr[ddc_pkg::ROW_MSB:ddc_pkg::ROW_LSB];
  // Column bits are split, so a contiguous page is only 1 KByte.
  // The critical word's column goes out first; memory wraps sequentially.
  assign cur_col = {1'b0, s_reg.cur.addr[ddc_pkg::COL_HI_MSB:ddc_pkg::COL_HI_LSB],
                    s_reg.cur.addr[ddc_pkg::COL_LO_MSB:ddc_pkg::COL_LO_LSB]};
  assign req_hit = s_reg.open_vld[req_idx] && (s_reg.open_row[req_idx] == req_row);
  assign rvalid_s = s_reg.sync2[16];
  assign rdata_s = s_reg.sync2[15:0];
  // Refresh and init commands take precedence over new accesses.
  assign idle_free = (s_reg.st == ddc_pkg::ST_IDLE) && !s_reg.precharge_all_command_pend && !s_reg.init_refresh_pend
                     && !(s_reg.ref_due && s_reg.ctl.auto_refresh_enable)
                     && !(s_reg.lmr_pend && s_reg.ctl.mode_write_enable);
  assign req_ready = idle_free;
  assign fifo_pop = (s_reg.st == ddc_pkg::ST_XFER) && s_reg.cur.write && !s_reg.half_cnt[0];
  assign mode_locked = !s_reg.ctl.mode_write_enable;
  assign ctrl_busy = (s_reg.st != ddc_pkg::ST_IDLE) || s_reg.precharge_all_command_pend || s_reg.init_refresh_pend;
  assign rd_valid = s_reg.rd_valid;
  assign rd_data = s_reg.rd_data;
  assign mem_out = s_reg.mem;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Commands are single-cycle pulses; each command state then waits the gap.
  always_comb begin
    s_next = s_reg;
    s_next.mem.cmd = ddc_pkg::CMD_NOP;
    s_next.mem.cs_n = '1;
    s_next.mem.wvalid = 1'b0;
    s_next.rd_valid = 1'b0;
    // Pin inputs pass two flops before use.
    s_next.sync1 = {mem_rvalid, mem_rdata};
    s_next.sync2 = s_reg.sync1;
    // Periodic refresh timer; clearing the enable restarts it.
    if (!s_reg.ctl.auto_refresh_enable || s_reg.ref_cnt == '0) begin
      s_next.ref_cnt = ddc_pkg::REF_LOAD;
    end else begin
      s_next.ref_cnt = s_reg.ref_cnt - 10'h001;
    end
    if (s_reg.wait_cnt != '0) begin
      s_next.wait_cnt = s_reg.wait_cnt - 4'h1;
    end
    case (s_reg.st)
      ddc_pkg::ST_IDLE: begin
        if (s_reg.ref_due && s_reg.ctl.auto_refresh_enable || s_reg.init_refresh_pend || s_reg.precharge_all_command_pend) begin
          // A refresh always starts by precharging every bank everywhere.
          s_next.then_ref = !s_reg.precharge_all_command_pend;
          s_next.mem.cmd = ddc_pkg::CMD_PRECHARGE_ALL_COMMAND;
          s_next.mem.cs_n = '0;
          s_next.open_vld = '0;
          s_next.st = ddc_pkg::ST_PRECHARGE_ALL_COMMAND;
          s_next.wait_cnt = ddc_pkg::GAP_LOAD;
          if (s_reg.precharge_all_command_pend) begin
            s_next.precharge_all_command_pend = 1'b0;
          end else if (s_reg.init_refresh_pend) begin
            s_next.init_refresh_pend = 1'b0;
          end else begin
            s_next.ref_due = 1'b0;
          end
        end else if (s_reg.lmr_pend && s_reg.ctl.mode_write_enable) begin
          s_next.lmr_pend = 1'b0;
          s_next.mem.cmd = ddc_pkg::CMD_LMR;
          s_next.mem.cs_n = '0;
          s_next.mem.bank = s_reg.lmr_sel;
          s_next.mem.addr = s_reg.lmr_val;
          s_next.st = ddc_pkg::ST_LMR;
          s_next.wait_cnt = ddc_pkg::GAP_LOAD;
        end else if (req_valid) begin
          s_next.cur = req;
          s_next.half_cnt = '0;
          s_next.mem.cs_n[req.addr[ddc_pkg::CS_BIT]] = 1'b0;
          s_next.mem.bank = req.addr[ddc_pkg::BANK_MSB:ddc_pkg::BANK_LSB];
          s_next.wait_cnt = ddc_pkg::GAP_LOAD;
          if (req_hit) begin
            s_next.mem.cmd = req.write ? ddc_pkg::CMD_WR : ddc_pkg::CMD_RD; // Open row: access at once.
            s_next.mem.addr = {1'b0, req.addr[ddc_pkg::COL_HI_MSB:ddc_pkg::COL_HI_LSB],
                               req.addr[ddc_pkg::COL_LO_MSB:ddc_pkg::COL_LO_LSB]};
            s_next.st = ddc_pkg::ST_XFER;
            s_next.wait_cnt = '0;
          end else if (s_reg.open_vld[req_idx]) begin
            // Outside the open page: close this bank's row first.
            s_next.mem.cmd = ddc_pkg::CMD_PRE;
            s_next.open_vld[req_idx] = 1'b0;
            s_next.st = ddc_pkg::ST_PRE;
          end else begin
            // Idle bank needs only an activate of that one bank.
            s_next.mem.cmd = ddc_pkg::CMD_ACT;
            s_next.mem.addr = {2'b00, req_row};
            s_next.open_vld[req_idx] = 1'b1;
            s_next.open_row[req_idx] = req_row;
            s_next.st = ddc_pkg::ST_ACT;
          end
        end
      end
      ddc_pkg::ST_PRECHARGE_ALL_COMMAND: begin
        if (s_reg.wait_cnt == '0) begin
          if (s_reg.then_ref) begin
            // Every chip-select refreshes together; all rows are now closed.
            s_next.mem.cmd = ddc_pkg::CMD_REF;
            s_next.mem.cs_n = '0;
            s_next.open_vld = '0;
            s_next.st = ddc_pkg::ST_REF;
            s_next.wait_cnt = ddc_pkg::GAP_LOAD;
          end else begin
            s_next.st = ddc_pkg::ST_IDLE;
          end
        end
      end
      ddc_pkg::ST_REF, ddc_pkg::ST_LMR: begin
        if (s_reg.wait_cnt == '0) begin
          s_next.st = ddc_pkg::ST_IDLE;
        end
      end
      ddc_pkg::ST_PRE: begin
        if (s_reg.wait_cnt == '0) begin
          s_next.mem.cmd = ddc_pkg::CMD_ACT;
          s_next.mem.cs_n[s_reg.cur.addr[ddc_pkg::CS_BIT]] = 1'b0;
          s_next.mem.addr = {2'b00, cur_row};
          s_next.open_vld[cur_idx] = 1'b1;
          s_next.open_row[cur_idx] = cur_row;
          s_next.st = ddc_pkg::ST_ACT;
          s_next.wait_cnt = ddc_pkg::GAP_LOAD;
        end
      end
      ddc_pkg::ST_ACT: begin
        if (s_reg.wait_cnt == '0) begin
          s_next.mem.cmd = s_reg.cur.write ? ddc_pkg::CMD_WR : ddc_pkg::CMD_RD; // Row is open now.
          s_next.mem.cs_n[s_reg.cur.addr[ddc_pkg::CS_BIT]] = 1'b0;
          s_next.mem.addr = cur_col;
          s_next.st = ddc_pkg::ST_XFER;
        end
      end
      ddc_pkg::ST_XFER: begin
        if (s_reg.cur.write) begin
          if (!s_reg.half_cnt[0] && fifo_valid) begin
            s_next.mem.wdata = fifo_data[15:0];
            s_next.lo_half = fifo_data[31:16];
            s_next.mem.wvalid = 1'b1;
            s_next.half_cnt = s_reg.half_cnt + 4'h1;
          end else if (s_reg.half_cnt[0]) begin
            s_next.mem.wdata = s_reg.lo_half;
            s_next.mem.wvalid = 1'b1;
            s_next.half_cnt = s_reg.half_cnt + 4'h1;
          end
        end else if (rvalid_s) begin
          if (!s_reg.half_cnt[0]) begin
            s_next.lo_half = rdata_s;
          end else begin
            s_next.rd_data = {rdata_s, s_reg.lo_half};
            s_next.rd_valid = 1'b1;
          end
          s_next.half_cnt = s_reg.half_cnt + 4'h1;
        end
        if (s_reg.half_cnt == ddc_pkg::HALF_LAST && (s_reg.cur.write || rvalid_s)) begin
          s_next.st = ddc_pkg::ST_IDLE;
        end
      end
      default: begin
        s_next.st = ddc_pkg::ST_IDLE;
      end
    endcase
    // Set wins over the clear above when the timer expires the same cycle.
    if (s_reg.ctl.auto_refresh_enable && s_reg.ref_cnt == '0) begin
      s_next.ref_due = 1'b1;
    end
    // A write to the control bits arms at most one init command.
    if (ctrl_wr) begin
      s_next.ctl = ctrl_in;
      if (ctrl_in.init_precharge_all && ctrl_in.mode_write_enable && !ctrl_in.init_refresh
          && !ctrl_in.auto_refresh_enable) begin
        s_next.precharge_all_command_pend = 1'b1;
      end
      if (ctrl_in.init_refresh && ctrl_in.mode_write_enable && !ctrl_in.init_precharge_all
          && !ctrl_in.auto_refresh_enable) begin
        s_next.init_refresh_pend = 1'b1;
      end
    end
    // Mode writes are dropped once the enable is cleared.
    if (mode_wr && s_reg.ctl.mode_write_enable) begin
      s_next.lmr_pend = 1'b1;
      s_next.lmr_sel = mode_sel;
      s_next.lmr_val = memory_mode_value;
    end
  end

  // Reset closes every tracked row so first accesses activate.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.st <= ddc_pkg::ST_IDLE;
      s_reg.mem.cs_n <= '1;
      s_reg.ref_cnt <= ddc_pkg::REF_LOAD;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_access_needs_act: assert property (
    (s_reg.mem.cmd == ddc_pkg::CMD_RD || s_reg.mem.cmd == ddc_pkg::CMD_WR)
      |-> s_reg.open_vld[cur_idx] && s_reg.open_row[cur_idx] == cur_row)
    else $error("Access issued to a bank without an active row.");
  a_ref_closes_all: assert property (
    s_reg.mem.cmd == ddc_pkg::CMD_REF |-> s_reg.open_vld == '0 && s_reg.mem.cs_n == '0)
    else $error("Refresh left a bank open or missed a chip-select.");
  a_pre_then_act: assert property (
    s_reg.mem.cmd == ddc_pkg::CMD_PRE |-> ##[1:GAP_WIN] s_reg.mem.cmd == ddc_pkg::CMD_ACT)
    else $error("Precharge was not followed by activate.");
  a_act_then_access: assert property (
    s_reg.mem.cmd == ddc_pkg::CMD_ACT |-> ##[1:GAP_WIN]
      (s_reg.mem.cmd == ddc_pkg::CMD_RD || s_reg.mem.cmd == ddc_pkg::CMD_WR))
    else $error("Activate was not followed by the access.");
  a_hit_direct: assert property (
    req_valid && req_ready && req_hit |=> (s_reg.mem.cmd == ddc_pkg::CMD_RD || s_reg.mem.cmd == ddc_pkg::CMD_WR))
    else $error("Row hit did not issue the access at once.");
  a_init_precharge_all_command: assert property (
    $rose(s_reg.precharge_all_command_pend) && s_reg.st == ddc_pkg::ST_IDLE |-> ##1 s_reg.mem.cmd == ddc_pkg::CMD_PRECHARGE_ALL_COMMAND)
    else $error("Init precharge-all was not issued.");
  a_lmr_locked: assert property (
    s_reg.mem.cmd == ddc_pkg::CMD_LMR |-> $past(s_reg.ctl.mode_write_enable))
    else $error("Mode write issued while locked.");
  a_rd_pair: assert property (
    s_reg.rd_valid |-> s_reg.rd_data[15:0] == $past(s_reg.lo_half) && s_reg.rd_data[31:16] == $past(rdata_s))
    else $error("Read word not packed from two halves.");
  a_burst_len: assert property (
    $past(s_reg.st == ddc_pkg::ST_XFER) && s_reg.st == ddc_pkg::ST_IDLE |-> $past(s_reg.half_cnt) == ddc_pkg::HALF_LAST)
    else $error("Burst ended before eight memory beats.");
  a_reset_clear: assert property (
    $past(rst) |-> s_reg.open_vld == '0)
    else $error("Open-row tracking not cleared by reset.");
endmodule : ddc_ctrl

//--- ddc_mem_model.sv
module ddc_mem_model #(
  parameter int LAT = 2
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire ddc_pkg::ddc_mem_t mem_out,
  output logic [15:0] mem_rdata,
  output logic mem_rvalid,
  output logic [7:0] viol_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] open_reg;
  logic [13:0] col_reg;
  int cnt_reg;
  logic [2:0] idx;

  // Bank slot addressed by the command now on the bus.
  assign idx = {mem_out.cs_n[0], mem_out.bank};

  // --------------------------------------------------------------
  // Bank tracking and read burst replay
  // --------------------------------------------------------------
  // Released data lines invert every cycle, so they alternate between the inverse of the last half and the last half itself.
  always @(posedge ref_clk) begin
    if (rst) begin
      open_reg <= '0;
      cnt_reg <= 0;
      viol_cnt <= 8'h00;
      mem_rvalid <= 1'b0;
      mem_rdata <= 16'h0000;
    end else begin
      mem_rvalid <= cnt_reg > 0 && cnt_reg <= 8;
      if (cnt_reg > 0 && cnt_reg <= 8) begin
        mem_rdata <= 16'h5A00 ^ 16'({col_reg[13:3], 3'(col_reg[2:0] + 3'(8 - cnt_reg))});
      end else begin
        mem_rdata <= ~mem_rdata;
      end
      if (cnt_reg > 0) begin
        cnt_reg <= cnt_reg - 1;
      end
      case (mem_out.cmd)
        ddc_pkg::CMD_ACT: begin
          if (open_reg[idx]) begin
            viol_cnt <= viol_cnt + 8'h01;
          end
          open_reg[idx] <= 1'b1;
        end
        ddc_pkg::CMD_PRE: open_reg[idx] <= 1'b0;
        ddc_pkg::CMD_PRECHARGE_ALL_COMMAND, ddc_pkg::CMD_REF: open_reg <= '0;
        ddc_pkg::CMD_RD, ddc_pkg::CMD_WR: begin
          if (!open_reg[idx]) begin
            viol_cnt <= viol_cnt + 8'h01;
          end
          if (mem_out.cmd == ddc_pkg::CMD_RD) begin
            col_reg <= mem_out.addr;
            cnt_reg <= LAT + 8;
          end
        end
        default: ;
      endcase
    end
  end
endmodule : ddc_mem_model

//--- ddr2_sdram_page_and_init_control_tb.sv
module ddr2_sdram_page_and_init_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, rst, ctrl_wr, mode_wr, mode_locked, ctrl_busy, req_valid, req_ready;
  logic wr_valid, wr_ready, rd_valid, mem_rvalid;
  logic [1:0] mode_sel;
  logic [13:0] mode_val;
  logic [31:0] wr_data, rd_data;
  logic [15:0] mem_rdata;
  logic [7:0] viol_cnt;
  ddc_pkg::ddc_ctl_t ctrl_in;
  ddc_pkg::ddc_req_t req;
  ddc_pkg::ddc_mem_t mem_out;
  ddc_pkg::ddc_mem_t eq[$];
  logic [31:0] wq[$];
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;

  ddc_ctrl ddc_ctrl_i (.ref_clk(ref_clk), .rst(rst), .ctrl_wr(ctrl_wr), .ctrl_in(ctrl_in), .mode_wr(mode_wr),
    .mode_sel(mode_sel), .memory_mode_value(mode_val), .mode_locked(mode_locked), .ctrl_busy(ctrl_busy),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data), .mem_out(mem_out), .mem_rdata(mem_rdata),
    .mem_rvalid(mem_rvalid));
  ddc_mem_model ddc_mem_model_i (.ref_clk(ref_clk), .rst(rst), .mem_out(mem_out), .mem_rdata(mem_rdata),
    .mem_rvalid(mem_rvalid), .viol_cnt(viol_cnt));

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic report_and_stop();
    $display("errors %0d of %0d checks", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  function automatic logic [15:0] half(input logic [13:0] c, input int k);
    return 16'h5A00 ^ 16'({c[13:3], 3'(c[2:0] + 3'(k))});
  endfunction : half

  // Expected command fields derived from the address split cs=A28, bank=A11:10, row=A23:12.
  function automatic ddc_pkg::ddc_mem_t mk(input ddc_pkg::ddc_cmd_t c, input logic [31:0] a);
    ddc_pkg::ddc_mem_t m;
    m = '0;
    m.cmd = c;
    m.cs_n = a[28] ? 2'h1 : 2'h2;
    m.bank = a[11:10];
    m.addr = (c == ddc_pkg::CMD_ACT) ? {2'h0, a[23:12]} : {1'b0, a[27:24], a[9:1]};
    return m;
  endfunction : mk

  task automatic all_cs(input ddc_pkg::ddc_cmd_t c);
    ddc_pkg::ddc_mem_t m;
    m = '0;
    m.cmd = c;
    eq.push_back(m);
  endtask : all_cs

  // Watches the memory side until every expected command, write half and read word is seen.
  task automatic run(input int lim, input int nh, input int nw, input logic [13:0] col);
    ddc_pkg::ddc_mem_t m;
    int i;
    int j;
    j = 0;
    for (i = 0; i < lim && (eq.size() > 0 || nh > 0 || nw > 0); i++) begin
      #1;
      if (mem_out.cmd !== ddc_pkg::CMD_NOP) begin
        m = '0;
        if (eq.size() > 0) m = eq.pop_front();
        chk("mem cmd", 32'(m.cmd), 32'(mem_out.cmd));
        chk("mem cs_n", 32'(m.cs_n), 32'(mem_out.cs_n));
        if (m.cmd != ddc_pkg::CMD_PRECHARGE_ALL_COMMAND && m.cmd != ddc_pkg::CMD_REF) chk("mem bank", 32'(m.bank), 32'(mem_out.bank));
        if (m.cmd > ddc_pkg::CMD_PRE && m.cmd != ddc_pkg::CMD_REF) chk("mem addr", 32'(m.addr), 32'(mem_out.addr));
      end
      if (mem_out.wvalid === 1'b1 && nh > 0) begin
        chk("write half", 32'(nh[0] ? wq[0][31:16] : wq[0][15:0]), 32'(mem_out.wdata));
        if (nh[0]) void'(wq.pop_front());
        nh--;
      end
      if (rd_valid === 1'b1 && nw > 0) begin
        chk("read word", {half(col, 2 * j + 1), half(col, 2 * j)}, rd_data);
        j++;
        nw--;
      end
      @(posedge ref_clk);
    end
    chk("burst complete", 32'h0, 32'(eq.size() + nh + nw));
  endtask : run

  task automatic quiet(input int n);
    repeat (n) begin
      #1;
      if (mem_out.cmd !== ddc_pkg::CMD_NOP) chk("idle cmd", 32'h0, 32'(mem_out.cmd));
      @(posedge ref_clk);
    end
  endtask : quiet

  task automatic pulse_ctl(input logic [3:0] v);
    @(posedge ref_clk);
    ctrl_in <= ddc_pkg::ddc_ctl_t'(v);
    ctrl_wr <= 1'b1;
    @(posedge ref_clk);
    ctrl_wr <= 1'b0;
  endtask : pulse_ctl

  task automatic do_mode(input logic [1:0] s, input logic [13:0] v, input logic exp);
    ddc_pkg::ddc_mem_t m;
    @(posedge ref_clk);
    mode_wr <= 1'b1;
    mode_sel <= s;
    mode_val <= v;
    @(posedge ref_clk);
    mode_wr <= 1'b0;
    m = '0;
    m.cmd = ddc_pkg::CMD_LMR;
    m.cs_n = 2'h0;
    m.bank = s;
    m.addr = v;
    if (exp) eq.push_back(m);
    if (exp) run(50, 0, 0, 14'h0000);
  endtask : do_mode

  // Request is held until req_ready is seen high at a falling edge, then through the next rising edge.
  task automatic access(input logic [31:0] a, input logic wr, input int kind);
    logic ok;
    int i;
    if (kind == 2) eq.push_back(mk(ddc_pkg::CMD_PRE, a));
    if (kind >= 1) eq.push_back(mk(ddc_pkg::CMD_ACT, a));
    eq.push_back(mk(wr ? ddc_pkg::CMD_WR : ddc_pkg::CMD_RD, a));
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req <= '{write: wr, addr: a};
    ok = 1'b0;
    for (i = 0; i < 50 && ok !== 1'b1; i++) begin
      @(negedge ref_clk);
      ok = req_ready;
      @(posedge ref_clk);
    end
    req_valid <= 1'b0;
    chk("request taken", 32'h1, 32'(ok));
    run(200, wr ? 8 : 0, wr ? 0 : 4, {1'b0, a[27:24], a[9:1]});
  endtask : access

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_init();
    @(negedge ref_clk);
    chk("locked at reset", 32'h1, 32'(mode_locked));
    chk("ready at reset", 32'h1, 32'(req_ready));
    chk("busy at reset", 32'h0, 32'(ctrl_busy));
    repeat (20000) @(posedge ref_clk);
    pulse_ctl(4'h3);
    @(negedge ref_clk);
    chk("busy after init write", 32'h1, 32'(ctrl_busy));
    all_cs(ddc_pkg::CMD_PRECHARGE_ALL_COMMAND);
    run(50, 0, 0, 14'h0000);
    @(negedge ref_clk);
    chk("unlocked", 32'h0, 32'(mode_locked));
    do_mode(2'h2, 14'h0000, 1'b1);
    do_mode(2'h3, 14'h0000, 1'b1);
    do_mode(2'h1, 14'h0000, 1'b1);
    do_mode(2'h0, 14'h0133, 1'b1);
    repeat (20) @(posedge ref_clk);
    pulse_ctl(4'h3);
    all_cs(ddc_pkg::CMD_PRECHARGE_ALL_COMMAND);
    run(50, 0, 0, 14'h0000);
    repeat (2) begin
      pulse_ctl(4'h5);
      all_cs(ddc_pkg::CMD_PRECHARGE_ALL_COMMAND);
      all_cs(ddc_pkg::CMD_REF);
      run(50, 0, 0, 14'h0000);
    end
    pulse_ctl(4'h7);
    quiet(10);
    do_mode(2'h0, 14'h0033, 1'b1);
    pulse_ctl(4'h0);
    @(negedge ref_clk);
    chk("locked", 32'h1, 32'(mode_locked));
    do_mode(2'h1, 14'h0001, 1'b0);
    quiet(10);
  endtask : t_init

  task automatic t_page();
    access(32'h0000_5406, 1'b0, 1);
    access(32'h0300_5412, 1'b0, 0);
    access(32'h0000_9406, 1'b0, 2);
    access(32'h1000_9406, 1'b0, 1);
    access(32'h0000_9408, 1'b0, 0);
  endtask : t_page

  // Fills the write buffer until it refuses, then drains it in four bursts.
  task automatic t_fifo();
    logic ok;
    int n;
    n = 0;
    ok = 1'b1;
    @(posedge ref_clk);
    wr_valid <= 1'b1;
    wr_data <= 32'hB001_B000;
    while (ok === 1'b1 && n < 20) begin
      @(negedge ref_clk);
      ok = wr_ready;
      @(posedge ref_clk);
      if (ok === 1'b1) begin
        wq.push_back(wr_data);
        n++;
        wr_data <= wr_data + 32'h0002_0002;
      end
    end
    wr_valid <= 1'b0;
    chk("words accepted", 32'h10, 32'(n));
    repeat (4) access(32'h0000_9480, 1'b1, 0);
    @(negedge ref_clk);
    chk("ready after drain", 32'h1, 32'(wr_ready));
  endtask : t_fifo

  task automatic t_refresh();
    pulse_ctl(4'h8);
    all_cs(ddc_pkg::CMD_PRECHARGE_ALL_COMMAND);
    all_cs(ddc_pkg::CMD_REF);
    run(1000, 0, 0, 14'h0000);
    access(32'h0000_9406, 1'b0, 1);
    chk("model violations", 32'h0, 32'(viol_cnt));
  endtask : t_refresh

  // --------------------------------------------------------------
  // Clock, timeout and main sequence
  // --------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // The ceiling allows the power-up wait plus a few refresh intervals of traffic.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  initial begin
    rst = 1'b1;
    ctrl_wr = 1'b0;
    ctrl_in = '0;
    mode_wr = 1'b0;
    mode_sel = 2'h0;
    mode_val = 14'h0000;
    req_valid = 1'b0;
    req = '0;
    wr_valid = 1'b0;
    wr_data = 32'h0000_0000;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_init();
    t_page();
    t_fifo();
    t_refresh();
    report_and_stop();
  end
endmodule : ddr2_sdram_page_and_init_control_tb
